//--- src/onoff_pkg.sv
// Purpose: constants and types for the on/off state controller
// Assumes: 100 MHz system clock
// Notes:   register map sits on an axi4-lite slave
package onoff_pkg;
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned CHG_DB_MS       = 120;          // charge input debounce, ms
   localparam int unsigned CHG_DB_CYC      = CHG_DB_MS * (CLK_HZ / 1000);
   localparam int unsigned HOLD_WAIT_MS    = 100;          // hold wait time, ms
   localparam int unsigned HOLD_WAIT_CYC   = HOLD_WAIT_MS * (CLK_HZ / 1000);
   localparam int unsigned SETTLE_CYC      = 16;           // settle before leaving reset
   localparam int unsigned SEQ_CYC         = 8;            // power-up sequence length

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_PERIPH = 8'h08;

   // ctrl fields
   localparam int unsigned CTRL_BIAS   = 0;
   localparam int unsigned CTRL_SRST_L = 1;
   localparam int unsigned CTRL_ONKEY  = 3;  // write one to clear onkey status
   localparam int unsigned CTRL_WAKE   = 4;  // write one to clear wake flag

   localparam logic [1:0] SRST_COLD = 2'h1;
   localparam logic [1:0] SRST_OFF  = 2'h2;
   localparam logic [1:0] RESP_OK   = 2'h0;
   localparam logic [1:0] RESP_ERR  = 2'h2;

   // gray codes along the wake path
   typedef enum logic [3:0] {
      ST_RESET    = 4'h0,
      ST_STANDBY  = 4'h1,
      ST_BIAS_UP  = 4'h3,
      ST_SEQ_UP   = 4'h2,
      ST_HOLD_CHK = 4'h6,
      ST_ON_CTRL  = 4'h7,
      ST_PWR_DOWN = 4'h5,
      ST_ON_SW    = 4'h9
   } state_t;
endpackage

//--- src/onoff_state_controller.sv
// Purpose: top-level on/off state machine with axi4-lite registers
// Assumes: inputs synchronous to sys_clk; debounce of onkey done upstream
// Notes:   power-down path is a short fixed wait back to standby
`timescale 1ns/1ns
// Function
// - hold state logic in reset below threshold
// - settle, release reset, enter standby
// - standby: bias off, awaiting wake, bus works
// - peripherals disabled in standby
// - bias enable write enters software on
// - bias enable clear returns to standby
// - software on: peripherals by register only
// - onkey falling edge wakes, sets status
// - charge rise stable 120 ms wakes
// - cold soft reset sets wake flag
// - wake: bias, bias ok, sequence, hold check
// - hold low, time left: keep waiting
// - hold wait expired: leave without on
// - hold high enters controller on state
// - combined hold is hold or charger wake
// - controller on: bias low power, sequencers on
// - hold low, soft reset, fault starts power-down
module onoff_state_controller #(
   parameter int unsigned CHG_DB_CYCLES    = onoff_pkg::CHG_DB_CYC,
   parameter int unsigned HOLD_WAIT_CYCLES = onoff_pkg::HOLD_WAIT_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        por_ok,
   input  wire logic        onkey_input_n,
   input  wire logic        charge_input,
   input  wire logic        power_hold_input,
   input  wire logic        bias_ok,
   input  wire logic        over_temp,
   input  wire logic        manual_reset,
   input  wire logic        io_supply_ok,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             main_bias_en,
   output logic             bias_low_power,
   output logic             sequencer_on,
   output logic [3:0]       periph_en
);
   // counters compare against count minus one, so a count below two cannot work
   if (CHG_DB_CYCLES < 2 || HOLD_WAIT_CYCLES < 2) begin : g_bad_counts
      $error("debounce and hold counts must be at least 2");
   end

   ////////////////////////////////////////////////////////////////////////////
   // state and flags
   onoff_pkg::state_t st_q, st_d;
   logic [31:0] tmr_q, tmr_d;        // shared settle, sequence and hold timer
   logic [31:0] chg_cnt_q, chg_cnt_d;
   logic        chg_stable_q, chg_stable_d;
   logic        key_prev_q, key_prev_d;
   logic        onkey_stat_q, onkey_stat_d;
   logic        wake_q, wake_d;
   logic        chg_wake_q, chg_wake_d;
   logic        bias_q, bias_d;
   logic [1:0]  srst_q, srst_d;
   logic [3:0]  periph_q, periph_d;
   logic        combined_hold, wake_evt, key_fall, chg_rise, timer_done;

   // bus handshake state
   logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
   logic [7:0]  awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [3:0]  ws_q, ws_d;
   logic [1:0]  br_q, br_d, rr_q, rr_d;
   logic        wr_fire;

   function automatic logic known_addr(input logic [7:0] a);
      return a == onoff_pkg::ADDR_CTRL || a == onoff_pkg::ADDR_STATUS ||
             a == onoff_pkg::ADDR_PERIPH;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave: address and data accepted in either order
   always_comb begin
      aw_d  = aw_q;
      w_d   = w_q;
      awa_d = awa_q;
      wd_d  = wd_q;
      ws_d  = ws_q;
      bv_d  = bv_q;
      br_d  = br_q;
      rv_d  = rv_q;
      rd_d  = rd_q;
      rr_d  = rr_q;
      if (s_axi_awvalid && !aw_q && !bv_q) begin
         aw_d  = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q && !bv_q) begin
         w_d  = 1'b1;
         wd_d = s_axi_wdata;
         ws_d = s_axi_wstrb;
      end
      wr_fire = aw_q && w_q && !bv_q;
      if (wr_fire) begin
         aw_d = 1'b0;
         w_d  = 1'b0;
         bv_d = 1'b1;
         br_d = known_addr(awa_q) ? onoff_pkg::RESP_OK : onoff_pkg::RESP_ERR;
      end else if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
      if (s_axi_arvalid && !rv_q) begin
         rv_d = 1'b1;
         rr_d = known_addr(s_axi_araddr) ? onoff_pkg::RESP_OK : onoff_pkg::RESP_ERR;
         case (s_axi_araddr)
            onoff_pkg::ADDR_CTRL:   rd_d = {27'h0, wake_q, onkey_stat_q, srst_q, bias_q};
            onoff_pkg::ADDR_STATUS: rd_d = {24'h0, chg_stable_q, combined_hold, bias_ok,
                                            io_supply_ok, st_q};
            onoff_pkg::ADDR_PERIPH: rd_d = {28'h0, periph_q};
            default:                rd_d = 32'h0;
         endcase
      end else if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_q  <= 1'b0;
         w_q   <= 1'b0;
         awa_q <= 8'h0;
         wd_q  <= 32'h0;
         ws_q  <= 4'h0;
         bv_q  <= 1'b0;
         br_q  <= 2'h0;
         rv_q  <= 1'b0;
         rd_q  <= 32'h0;
         rr_q  <= 2'h0;
      end else begin
         aw_q  <= aw_d;
         w_q   <= w_d;
         awa_q <= awa_d;
         wd_q  <= wd_d;
         ws_q  <= ws_d;
         bv_q  <= bv_d;
         br_q  <= br_d;
         rv_q  <= rv_d;
         rd_q  <= rd_d;
         rr_q  <= rr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // wake detection and main state machine
   assign key_fall      = key_prev_q && !onkey_input_n;
   assign chg_rise      = chg_cnt_q == CHG_DB_CYCLES - 1 && charge_input && !chg_stable_q;
   assign combined_hold = power_hold_input || (chg_wake_q && chg_stable_q);
   assign wake_evt      = onkey_stat_q || chg_wake_q || wake_q;
   assign timer_done    = tmr_q == HOLD_WAIT_CYCLES - 1;

   always_comb begin
      st_d         = st_q;
      tmr_d        = tmr_q + 32'h1;
      key_prev_d   = onkey_input_n;
      onkey_stat_d = onkey_stat_q;
      wake_d       = wake_q;
      chg_wake_d   = chg_wake_q && chg_stable_q;
      bias_d       = bias_q;
      srst_d       = 2'h0;                 // soft reset code acts once
      periph_d     = periph_q;
      // charge input must stay level for the whole window before it counts
      chg_cnt_d    = (charge_input != chg_stable_q) ? chg_cnt_q + 32'h1 : 32'h0;
      chg_stable_d = chg_stable_q;
      if (chg_cnt_q == CHG_DB_CYCLES - 1) begin
         chg_stable_d = charge_input;
         chg_cnt_d    = 32'h0;
      end
      // register writes; a hardware set in the same cycle wins below
      if (wr_fire && awa_q == onoff_pkg::ADDR_CTRL && ws_q[0]) begin
         bias_d = wd_q[onoff_pkg::CTRL_BIAS];
         srst_d = wd_q[onoff_pkg::CTRL_SRST_L +: 2];
         if (wd_q[onoff_pkg::CTRL_ONKEY]) onkey_stat_d = 1'b0;
         if (wd_q[onoff_pkg::CTRL_WAKE])  wake_d = 1'b0;
      end
      if (wr_fire && awa_q == onoff_pkg::ADDR_PERIPH && ws_q[0] && st_q == onoff_pkg::ST_ON_SW)
         periph_d = wd_q[3:0];
      if (srst_q == onoff_pkg::SRST_COLD) wake_d = 1'b1;
      if (st_q == onoff_pkg::ST_STANDBY && key_fall) onkey_stat_d = 1'b1;
      if (st_q == onoff_pkg::ST_STANDBY && chg_rise) chg_wake_d = 1'b1;
      case (st_q)
         onoff_pkg::ST_RESET: begin
            if (tmr_q == onoff_pkg::SETTLE_CYC - 1) st_d = onoff_pkg::ST_STANDBY;
         end
         onoff_pkg::ST_STANDBY: begin
            periph_d = 4'h0;
            if (bias_q) st_d = onoff_pkg::ST_ON_SW;
            else if (wake_evt) st_d = onoff_pkg::ST_BIAS_UP;
            tmr_d = 32'h0;
         end
         onoff_pkg::ST_ON_SW: begin
            if (!bias_q) st_d = onoff_pkg::ST_STANDBY;
         end
         onoff_pkg::ST_BIAS_UP: begin
            tmr_d = 32'h0;
            if (bias_ok) st_d = onoff_pkg::ST_SEQ_UP;
         end
         onoff_pkg::ST_SEQ_UP: begin
            if (tmr_q == onoff_pkg::SEQ_CYC - 1) begin
               st_d  = onoff_pkg::ST_HOLD_CHK;
               tmr_d = 32'h0;
            end
         end
         onoff_pkg::ST_HOLD_CHK: begin
            if (combined_hold) st_d = onoff_pkg::ST_ON_CTRL;
            else if (timer_done) st_d = onoff_pkg::ST_PWR_DOWN;
            if (st_d != st_q) tmr_d = 32'h0;
         end
         onoff_pkg::ST_ON_CTRL: begin
            tmr_d = 32'h0;
            if (!combined_hold || srst_q == onoff_pkg::SRST_COLD ||
                srst_q == onoff_pkg::SRST_OFF || over_temp || manual_reset)
               st_d = onoff_pkg::ST_PWR_DOWN;
         end
         onoff_pkg::ST_PWR_DOWN: begin
            onkey_stat_d = 1'b0;
            chg_wake_d   = 1'b0;
            if (tmr_q == onoff_pkg::SEQ_CYC - 1) st_d = onoff_pkg::ST_STANDBY;
         end
         default: st_d = onoff_pkg::ST_RESET;
      endcase
      // the wake flag survives power-down only when a cold reset caused it
      if (st_d == onoff_pkg::ST_PWR_DOWN && st_q != onoff_pkg::ST_PWR_DOWN &&
          srst_q != onoff_pkg::SRST_COLD) wake_d = 1'b0;
      if (!por_ok) st_d = onoff_pkg::ST_RESET;
      // low supply wipes software and wake state, not only the state code
      if (!por_ok) begin
         tmr_d        = 32'h0;
         bias_d       = 1'b0;
         wake_d       = 1'b0;
         onkey_stat_d = 1'b0;
         chg_wake_d   = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q         <= onoff_pkg::ST_RESET;
         tmr_q        <= 32'h0;
         key_prev_q   <= 1'b1;
         onkey_stat_q <= 1'b0;
         wake_q       <= 1'b0;
         chg_wake_q   <= 1'b0;
         chg_cnt_q    <= 32'h0;
         chg_stable_q <= 1'b0;
         bias_q       <= 1'b0;
         srst_q       <= 2'h0;
         periph_q     <= 4'h0;
      end else begin
         st_q         <= st_d;
         tmr_q        <= tmr_d;
         key_prev_q   <= key_prev_d;
         onkey_stat_q <= onkey_stat_d;
         wake_q       <= wake_d;
         chg_wake_q   <= chg_wake_d;
         chg_cnt_q    <= chg_cnt_d;
         chg_stable_q <= chg_stable_d;
         bias_q       <= bias_d;
         srst_q       <= srst_d;
         periph_q     <= periph_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs; bias stays off in reset and standby
   logic mb_q, lp_q, sq_q;
   logic [3:0] pe_q;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         mb_q <= 1'b0;
         lp_q <= 1'b0;
         sq_q <= 1'b0;
         pe_q <= 4'h0;
      end else begin
         mb_q <= st_d != onoff_pkg::ST_RESET && st_d != onoff_pkg::ST_STANDBY;
         lp_q <= st_d == onoff_pkg::ST_ON_CTRL;
         sq_q <= st_d == onoff_pkg::ST_ON_CTRL;
         pe_q <= (st_d == onoff_pkg::ST_ON_SW) ? periph_d : 4'h0;
      end
   end
   assign main_bias_en   = mb_q;
   assign bias_low_power = lp_q;
   assign sequencer_on   = sq_q;
   assign periph_en      = pe_q;
   assign s_axi_awready  = !aw_q && !bv_q;
   assign s_axi_wready   = !w_q && !bv_q;
   assign s_axi_bvalid   = bv_q;
   assign s_axi_bresp    = br_q;
   assign s_axi_arready  = !rv_q;
   assign s_axi_rvalid   = rv_q;
   assign s_axi_rdata    = rd_q;
   assign s_axi_rresp    = rr_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_por_holds_reset: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !por_ok |=> st_q == onoff_pkg::ST_RESET) else $error("no reset below threshold");
   a_standby_bias_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
      st_q == onoff_pkg::ST_STANDBY |-> !main_bias_en) else $error("bias on in standby");
   a_standby_periph_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
      st_q == onoff_pkg::ST_STANDBY |=> periph_en == 4'h0) else $error("periph in standby");
   a_bias_sw_on: assert property (@(posedge sys_clk) disable iff (!reset_n)
      st_q == onoff_pkg::ST_STANDBY && bias_q && por_ok |=> st_q == onoff_pkg::ST_ON_SW)
      else $error("no software on");
   a_bias_sw_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
      st_q == onoff_pkg::ST_ON_SW && !bias_q && por_ok |=> st_q == onoff_pkg::ST_STANDBY)
      else $error("no return to standby");
   a_hold_enters_on: assert property (@(posedge sys_clk) disable iff (!reset_n)
      st_q == onoff_pkg::ST_HOLD_CHK && combined_hold && por_ok |=> sequencer_on)
      else $error("hold did not enter on");
   a_hold_waits: assert property (@(posedge sys_clk) disable iff (!reset_n)
      st_q == onoff_pkg::ST_HOLD_CHK && !combined_hold && !timer_done && por_ok
      |=> st_q == onoff_pkg::ST_HOLD_CHK) else $error("hold check left early");
   a_on_power_down: assert property (@(posedge sys_clk) disable iff (!reset_n)
      st_q == onoff_pkg::ST_ON_CTRL && (over_temp || manual_reset) && por_ok
      |=> st_q == onoff_pkg::ST_PWR_DOWN) else $error("no power-down");
endmodule

//--- testbench/proc_model.sv
// Purpose: processor model that raises the power hold input once booted
// Assumes: boot starts when main bias comes up
// Notes:   bench sets boot delay and may withhold the hold entirely
`timescale 1ns/1ns
module proc_model (
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   input  wire logic       main_bias_en,
   input  wire logic       boot_en,
   input  wire logic [7:0] boot_dly,
   output logic            power_hold_input
);
   logic [7:0] cnt_q;
   // boot counter saturates so a long on state never wraps the hold low
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q            <= 8'h00;
         power_hold_input <= 1'b0;
      end else begin
         if (!main_bias_en) begin
            cnt_q <= 8'h00;
         end else if (cnt_q != 8'hff) begin
            cnt_q <= cnt_q + 8'h01;
         end
         power_hold_input <= boot_en && main_bias_en && (cnt_q >= boot_dly);
      end
   end
endmodule

//--- testbench/tb_top.sv
// Purpose: self-checking bench for the on/off state controller
// Assumes: short debounce and hold wait parameters
// Notes:   read results are queued by the driver and checked by a monitor
`timescale 1ns/1ns
module tb_top;
   logic        sys_clk, reset_n, por_ok, onkey_input_n, charge_input, power_hold_input;
   logic        bias_ok, over_temp, manual_reset, io_supply_ok, boot_en, saw_on;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, boot_dly;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_v, rv;
   logic [3:0]  s_axi_wstrb, periph_en;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        main_bias_en, bias_low_power, sequencer_on;
   logic [65:0] rq[$];
   logic [1:0]  bq[$];
   int          fails, total_checks, cyc;
   integer      seed;
   onoff_state_controller #(.CHG_DB_CYCLES(8), .HOLD_WAIT_CYCLES(20)) i_onoff_state_controller (
      .sys_clk, .reset_n, .por_ok, .onkey_input_n, .charge_input, .power_hold_input, .bias_ok,
      .over_temp, .manual_reset, .io_supply_ok, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .main_bias_en, .bias_low_power, .sequencer_on, .periph_en);
   proc_model i_proc_model (.sys_clk, .reset_n, .main_bias_en, .boot_en, .boot_dly,
      .power_hold_input);
   ////////////////////////////////////////////////////////////////////////////////
   always #5 sys_clk = ~sys_clk;
   task automatic conclude();
      if (fails == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // monitor: oldest note is compared whenever a response is taken
   always @(posedge sys_clk) begin
      cyc++;
      if (sequencer_on === 1'b1) saw_on <= 1'b1;
      if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
         chk(s_axi_rdata & rq[0][33:2], rq[0][65:34] & rq[0][33:2]);
         chk({30'h0, s_axi_rresp}, {30'h0, rq[0][1:0]});
         void'(rq.pop_front());
      end
      if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
         chk({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
      if (cyc > 60000) begin
         fails++;
         conclude();
      end
   end
   // ready lines stay high, so a task never lowers and raises them in one step
   task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] er);
      rq.push_back({e, m, er});
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      @(posedge sys_clk);
      while (!s_axi_arready) @(posedge sys_clk);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge sys_clk);
      rd_v = s_axi_rdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w;
      aw = 1'b1;
      w  = 1'b1;
      bq.push_back(er);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wvalid  <= 1'b1;
      while (aw || w) begin
         @(posedge sys_clk);
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (!s_axi_bvalid) @(posedge sys_clk);
   endtask
   // poll the state code under a bounded count, then compare it once
   task automatic wait_st(input logic [3:0] s);
      int i;
      i = 0;
      rd(8'h04, 32'h0, 32'h0, 2'h0);
      while (rd_v[3:0] !== s && i < 300) begin
         rd(8'h04, 32'h0, 32'h0, 2'h0);
         i++;
      end
      chk({28'h0, rd_v[3:0]}, {28'h0, s});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {sys_clk, reset_n, por_ok, charge_input, bias_ok, over_temp, manual_reset} = 7'h00;
      {onkey_input_n, io_supply_ok, s_axi_bready, s_axi_rready} = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, boot_en, saw_on} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, boot_dly} = 24'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      seed = 32'h5a0a96c1;
      repeat (5) @(posedge sys_clk);
      chk({25'h0, main_bias_en, bias_low_power, sequencer_on, periph_en}, 32'h0);
      reset_n <= 1'b1;
      repeat (30) @(posedge sys_clk);
      rd(8'h04, 32'h0, 32'hf, 2'h0);
      por_ok <= 1'b1;
      wait_st(4'h1);
      rd(8'h0c, 32'h0, 32'hffffffff, 2'h2);
      wr(8'h08, 32'hf, 2'h0);
      rd(8'h08, 32'h0, 32'hf, 2'h0);
      chk({27'h0, main_bias_en, periph_en}, 32'h0);
      wr(8'h00, 32'h1, 2'h0);
      wait_st(4'h9);
      rv = $random(seed);
      wr(8'h08, rv & 32'hf, 2'h0);
      repeat (2) @(posedge sys_clk);
      chk({27'h0, main_bias_en, periph_en}, {27'h0, 1'b1, rv[3:0]});
      wr(8'h00, 32'h0, 2'h0);
      wait_st(4'h1);
      repeat (2) @(posedge sys_clk);
      chk({27'h0, main_bias_en, periph_en}, 32'h0);
      // each pass ends the on state by a different cause
      for (int k = 0; k < 4; k++) begin
         boot_en <= 1'b1;
         boot_dly <= 8'($random(seed)) & 8'h0f;
         onkey_input_n <= 1'b0;
         wait_st(4'h3);
         onkey_input_n <= 1'b1;
         rd(8'h00, 32'h8, 32'h8, 2'h0);
         bias_ok <= 1'b1;
         wait_st(4'h7);
         chk({30'h0, bias_low_power, sequencer_on}, 32'h3);
         wr(8'h00, 32'h8, 2'h0);
         case (k)
            0: boot_en <= 1'b0;
            1: over_temp <= 1'b1;
            2: manual_reset <= 1'b1;
            default: wr(8'h00, 32'h4, 2'h0);
         endcase
         wait_st(4'h1);
         {over_temp, manual_reset, bias_ok, boot_en} <= 4'h0;
         @(posedge sys_clk);
      end
      // no hold at all: the wait must time out
      onkey_input_n <= 1'b0;
      wait_st(4'h3);
      onkey_input_n <= 1'b1;
      wr(8'h00, 32'h8, 2'h0);
      bias_ok <= 1'b1;
      saw_on <= 1'b0;
      wait_st(4'h6);
      rd(8'h04, 32'h6, 32'hf, 2'h0);
      wait_st(4'h1);
      chk({31'h0, saw_on}, 32'h0);
      bias_ok <= 1'b0;
      boot_en <= 1'b1;
      wr(8'h00, 32'h2, 2'h0);
      rd(8'h00, 32'h10, 32'h10, 2'h0);
      bias_ok <= 1'b1;
      wait_st(4'h7);
      wr(8'h00, 32'h10, 2'h0);
      boot_en <= 1'b0;
      wait_st(4'h1);
      bias_ok <= 1'b0;
      // short charge glitch is rejected, a steady one wakes and holds
      charge_input <= 1'b1;
      repeat (4) @(posedge sys_clk);
      charge_input <= 1'b0;
      repeat (12) @(posedge sys_clk);
      rd(8'h04, 32'h11, 32'h1f, 2'h0);
      charge_input <= 1'b1;
      wait_st(4'h3);
      bias_ok <= 1'b1;
      wait_st(4'h7);
      charge_input <= 1'b0;
      wait_st(4'h1);
      conclude();
   end
endmodule
